// *** design/hvs_params.svh ***
// constants of the h/v sync processor: offsets, thresholds, reset values, timings
// assumes a 100 MHz clock and the 8-bit register port of hvs_sync_proc
//
// Operation
// - pulses shorter than one oscillator period are ignored as noise
// - composite vertical detected flag set while vertical pulses come out of hsync
// - software may pick the extracted composite vertical for polarity, count, blanking
// - extracted composite vertical sync lags the composite input by 8 us
// - during composite vertical, insert pulses of 1/8 h period into h blanking
// - 14-bit counter times 64 h periods, then loads the h count latches
// - h count equals 128000000 / h frequency minus one
// - h latch updates once per vertical period if present, else continuously
// - 12-bit vertical counter holds 62500 / v frequency, updated each v period
// - each counter has an overflow status bit
// - frequency change flag set when latched count changes or counter overflows
// - h present set above 10 kHz, cleared below 10 Hz
// - v present set above 40 Hz, cleared below 10 Hz
// - h presence change flag set when h present changes
// - v presence change flag on v or composite present change; composite off masks
// - polarity negative when high pulse longer than low pulse, else positive
// - polarity change flags set when detected polarity changes
// - blanking outputs muxed by software, each with software polarity
// - vertical blanking forced off above 200 Hz vertical rate
// - blanking outputs share port bits 1 and 0, test pattern shares bit 2
// - self-test gives cross-hatch positive, negative, full white, full black
// - self-test h rate 63.5, 47.6 or 31.75 kHz, v rate 60 Hz
// - overflow bits clear themselves once the overflow is gone
// - source select 11 composite, 10 vsync, 00 composite off, 01 automatic
`ifndef HVS_PARAMS_SVH
`define HVS_PARAMS_SVH

// clock and measurement time bases
`define HVS_CLK_NS       10
`define HVS_OSC_NS       84
`define HVS_OSC_CYC      ((`HVS_OSC_NS + `HVS_CLK_NS - 1) / `HVS_CLK_NS)
`define HVS_TICKH_NS     500
`define HVS_TICKH_CYC    (`HVS_TICKH_NS / `HVS_CLK_NS)
`define HVS_TICKV_NS     16000
`define HVS_TICKV_CYC    (`HVS_TICKV_NS / `HVS_CLK_NS)
`define HVS_CVLAG_NS     8000
`define HVS_CVLAG_TICKS  (`HVS_CVLAG_NS / `HVS_TICKH_NS)
`define HVS_CVBROAD_CYC  (`HVS_CVLAG_NS / `HVS_CLK_NS)

// presence thresholds in 16 us ticks
`define HVS_HSET_US      100
`define HVS_VSET_US      25000
`define HVS_CLR_US       100000
`define HVS_HSET_TICKS   (`HVS_HSET_US * 1000 / `HVS_TICKV_NS)
`define HVS_VSET_TICKS   (`HVS_VSET_US * 1000 / `HVS_TICKV_NS)
`define HVS_CLR_TICKS    (`HVS_CLR_US * 1000 / `HVS_TICKV_NS)

// vertical cut-off: 200 Hz gives 5000 us per frame
`define HVS_VCUT_US      5000
`define HVS_VCUT_TICKS   (`HVS_VCUT_US * 1000 / `HVS_TICKV_NS)

// self-test timing
`define HVS_ST_HTOT0_NS  31500
`define HVS_ST_HTOT1_NS  21000
`define HVS_ST_HTOT2_NS  15750
`define HVS_ST_HSW0_NS   3000
`define HVS_ST_HSW1_NS   2000
`define HVS_ST_HSW2_NS   1500
`define HVS_ST_VTOT_US   16663
`define HVS_ST_VSW_US    63
`define HVS_ST_VTOT_CYC  (`HVS_ST_VTOT_US * 1000 / `HVS_CLK_NS)
`define HVS_ST_VSW_CYC   (`HVS_ST_VSW_US * 1000 / `HVS_CLK_NS)

// register offsets
`define HVS_A_PORT4      8'h38
`define HVS_A_STATUS     8'h40
`define HVS_A_HCNT_HI    8'h41
`define HVS_A_HCNT_LO    8'h42
`define HVS_A_VCNT_HI    8'h43
`define HVS_A_VCNT_LO    8'h44
`define HVS_A_CTRL0      8'h40
`define HVS_A_CTRL2      8'h42
`define HVS_A_FLAGS      8'h48
`define HVS_A_ENABLE     8'h49
`define HVS_A_PINSEL     8'h4a

// reset values
`define HVS_RST_BYTE     8'h00
`define HVS_RST_PINSEL   3'h0

`endif

// *** design/hvs_pkg.sv ***
// types of the h/v sync processor
// assumes hvs_params.svh for all numeric constants
`default_nettype none
package hvs_pkg;

	// sync source select codes
	typedef enum logic [1:0] {
		HVS_SRC_OFF  = 2'h0,
		HVS_SRC_AUTO = 2'h1,
		HVS_SRC_V    = 2'h2,
		HVS_SRC_CV   = 2'h3
	} hvs_src_e;

	// control register 0
	typedef struct packed {
		hvs_src_e   src;
		logic       no_insert;
		logic [2:0] unused;
		logic       hb_neg;
		logic       vb_neg;
	} hvs_ctl0_s;

	// control register 2: self-test
	typedef struct packed {
		logic [1:0] unused;
		logic       st_en;
		logic [1:0] st_rate;
		logic [1:0] st_pat;
		logic       unused0;
	} hvs_ctl2_s;

	// sticky change flags, bits 7..2 of the flag register
	typedef struct packed {
		logic hpr;
		logic vpr;
		logic hpl;
		logic vpl;
		logic hf;
		logic vf;
	} hvs_flags_s;

endpackage : hvs_pkg
`default_nettype wire

// *** design/hvs_sync_proc.sv ***
// h/v sync processor: separation, insertion, presence, counting, polarity, blanking, self-test
// assumes asynchronous sync pins and a single-cycle register port on clock_i
`include "hvs_params.svh"
`default_nettype none
module hvs_sync_proc
	import hvs_pkg::*;
#(
	parameter int unsigned ST_VTOT_CYC = `HVS_ST_VTOT_CYC,
	parameter int unsigned ST_VSW_CYC  = `HVS_ST_VSW_CYC,
	parameter int unsigned CLR_TICKS   = `HVS_CLR_TICKS
) (
	// clock, reset, enable
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	// register port
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       we_i,
	input  wire logic       re_i,
	output logic      [7:0] rdata_o,
	// sync pins
	input  wire logic       hsync_i,
	input  wire logic       vsync_i,
	// outputs
	output logic            horiz_blank_out_o,
	output logic            vert_blank_out_o,
	output logic            test_pattern_out_o,
	output logic      [2:0] port4_o,
	output logic            irq_o
);

	// software registers
	hvs_ctl0_s  ctl0;
	hvs_ctl2_s  ctl2;
	hvs_flags_s flg;
	hvs_flags_s flg_en;
	logic [2:0] port4;
	logic [2:0] pinsel;

	// two-stage synchronisers, first stage read only by second
	logic [1:0] hs_m, vs_m;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			hs_m <= 2'h0;
			vs_m <= 2'h0;
		end else if (ce_i) begin
			hs_m <= {hs_m[0], hsync_i};
			vs_m <= {vs_m[0], vsync_i};
		end
	end

	// time base ticks: 2 MHz for h, 62.5 kHz for v
	logic [5:0]  tkh_cnt;
	logic [10:0] tkv_cnt;
	wire         tick_h = (tkh_cnt == 6'(`HVS_TICKH_CYC - 1));
	wire         tick_v = (tkv_cnt == 11'(`HVS_TICKV_CYC - 1));
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tkh_cnt <= 6'h00;
			tkv_cnt <= 11'h000;
		end else if (ce_i) begin
			tkh_cnt <= tick_h ? 6'h00 : tkh_cnt + 6'h01;
			tkv_cnt <= tick_v ? 11'h000 : tkv_cnt + 11'h001;
		end
	end

	// glitch filter: a level must hold one oscillator period
	logic [1:0] filt;
	logic [1:0] filt_d;
	wire  [1:0] raw = {vs_m[1], hs_m[1]};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_filt
			logic [3:0] fcnt;
			always_ff @(posedge clock_i) begin
				if (rst_i) begin
					fcnt        <= 4'h0;
					filt[gi]    <= 1'b0;
				end else if (ce_i) begin
					if (raw[gi] == filt[gi])
						fcnt <= 4'h0;
					else if (fcnt == 4'(`HVS_OSC_CYC - 1)) begin
						fcnt     <= 4'h0;
						filt[gi] <= raw[gi];
					end else
						fcnt <= fcnt + 4'h1;
				end
			end
		end
	endgenerate

	always_ff @(posedge clock_i) begin
		if (rst_i)
			filt_d <= 2'h0;
		else if (ce_i)
			filt_d <= filt;
	end

	// polarity, presence and composite state
	logic [1:0] pol_neg;
	logic [2:0] pres;
	logic       cv;
	logic       cv_d;
	wire        hs_act = filt[0] ^ pol_neg[0];
	wire        hs_act_d = filt_d[0] ^ pol_neg[0];
	wire        h_edge = hs_act & ~hs_act_d;
	wire        comp_on = (ctl0.src != HVS_SRC_OFF);

	// source selection, automatic switch on composite only
	wire use_cv = (ctl0.src == HVS_SRC_CV) ||
		(ctl0.src == HVS_SRC_AUTO && pres[2] && !pres[1]);
	wire vs_act   = filt[1] ^ pol_neg[1];
	wire vs_act_d = filt_d[1] ^ pol_neg[1];
	wire vsel     = use_cv ? cv : vs_act;
	wire vsel_d   = use_cv ? cv_d : vs_act_d;
	wire v_edge   = vsel & ~vsel_d;
	wire vsel_pres = use_cv ? pres[2] : pres[1];

	// polarity: compare last high pulse with following low pulse
	wire [1:0] pol_lvl  = {use_cv ? cv : filt[1], filt[0]};
	wire [1:0] pol_lvld = {use_cv ? cv_d : filt_d[1], filt_d[0]};
	wire [1:0] pol_tk   = {tick_v, tick_h};
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pol
			logic [15:0] hi_cnt, lo_cnt, hi_last;
			always_ff @(posedge clock_i) begin
				if (rst_i) begin
					hi_cnt      <= 16'h0000;
					lo_cnt      <= 16'h0000;
					hi_last     <= 16'h0000;
					pol_neg[gi] <= 1'b0;
				end else if (ce_i) begin
					if (pol_lvl[gi] & ~pol_lvld[gi]) begin
						pol_neg[gi] <= (hi_last > lo_cnt);
						lo_cnt      <= 16'h0000;
					end else if (~pol_lvl[gi] & pol_lvld[gi]) begin
						hi_last <= hi_cnt;
						hi_cnt  <= 16'h0000;
					end else if (pol_tk[gi]) begin
						if (pol_lvl[gi] && hi_cnt != 16'hffff)
							hi_cnt <= hi_cnt + 16'h0001;
						if (!pol_lvl[gi] && lo_cnt != 16'hffff)
							lo_cnt <= lo_cnt + 16'h0001;
					end
				end
			end
		end
	endgenerate

	// presence: edge soon enough sets, long silence clears
	wire [2:0] pr_edge = {cv & ~cv_d & comp_on, vs_act & ~vs_act_d, h_edge};
	generate
		for (gi = 0; gi < 3; gi++) begin : g_pres
			localparam logic [15:0] SET_TH = (gi == 0) ? 16'(`HVS_HSET_TICKS) : 16'(`HVS_VSET_TICKS);
			logic [15:0] tmr;
			always_ff @(posedge clock_i) begin
				if (rst_i) begin
					tmr      <= 16'h0000;
					pres[gi] <= 1'b0;
				end else if (ce_i) begin
					if (pr_edge[gi]) begin
						if (tmr <= SET_TH)
							pres[gi] <= 1'b1;
						tmr <= 16'h0000;
					end else if (tick_v) begin
						if (tmr >= 16'(CLR_TICKS))
							pres[gi] <= 1'b0;
						else
							tmr <= tmr + 16'h0001;
					end
				end
			end
		end
	endgenerate

	// h period in 2 MHz ticks for extraction and insertion
	logic [11:0] hper_run, hper_last;
	logic [11:0] ins_cnt;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			hper_run  <= 12'h000;
			hper_last <= 12'h000;
			ins_cnt   <= 12'h000;
		end else if (ce_i) begin
			if (h_edge) begin
				hper_last <= hper_run;
				hper_run  <= 12'h000;
				ins_cnt   <= 12'h000;
			end else if (tick_h) begin
				if (hper_run != 12'hfff)
					hper_run <= hper_run + 12'h001;
				if (ins_cnt != 12'hfff)
					ins_cnt <= ins_cnt + 12'h001;
			end
		end
	end

	// broad pulse past the lag starts extracted vertical; held one line plus the lag
	logic [9:0]  act_len;
	logic [12:0] cv_hold;
	wire         broad = hs_act && act_len == 10'(`HVS_CVBROAD_CYC - 1);
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			act_len <= 10'h000;
			cv_hold <= 13'h0000;
			cv      <= 1'b0;
			cv_d    <= 1'b0;
		end else if (ce_i) begin
			act_len <= (hs_act && !broad) ? act_len + 10'h001 : (hs_act ? act_len : 10'h000);
			if (broad && comp_on)
				cv_hold <= {1'b0, hper_last} + 13'(`HVS_CVLAG_TICKS);
			else if (tick_h && cv_hold != 13'h0000)
				cv_hold <= cv_hold - 13'h0001;
			cv   <= (cv_hold != 13'h0000);
			cv_d <= cv;
		end
	end

	// inserted pulse: 1/8 of the last h period, restarted on each h edge
	wire ins_pulse = (ins_cnt < {3'h0, hper_last[11:3]});
	wire comp_h    = (cv && !ctl0.no_insert) ? ins_pulse : hs_act;

	// h counter over 64 periods; overflow when saturated
	logic [13:0] hc_run, h_res, hcnt_lat;
	logic        hc_ovf, h_res_ovf, hovf, h_res_vld;
	logic [5:0]  hper_cnt;
	wire         h_fin  = h_edge && hper_cnt == 6'h3f;
	// latch on the vertical edge while present, else at once
	wire         h_take = h_res_vld && (!vsel_pres || v_edge);
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			hc_run    <= 14'h0000;
			hc_ovf    <= 1'b0;
			hper_cnt  <= 6'h00;
			h_res     <= 14'h0000;
			h_res_ovf <= 1'b0;
			h_res_vld <= 1'b0;
			hcnt_lat  <= 14'h0000;
			hovf      <= 1'b0;
		end else if (ce_i) begin
			if (h_edge)
				hper_cnt <= hper_cnt + 6'h01;
			if (h_fin) begin
				h_res     <= (hc_run == 14'h0000) ? 14'h0000 : hc_run - 14'h0001;
				h_res_ovf <= hc_ovf;
				// a tick on the closing edge belongs to the next window, never lost
				hc_run    <= tick_h ? 14'h0001 : 14'h0000;
				hc_ovf    <= 1'b0;
			end else if (tick_h) begin
				if (hc_run == 14'h3fff)
					hc_ovf <= 1'b1;
				else
					hc_run <= hc_run + 14'h0001;
			end
			h_res_vld <= h_fin ? 1'b1 : (h_take ? 1'b0 : h_res_vld);
			// overflow bit follows the newest result
			if (h_take) begin
				hcnt_lat <= h_res;
				hovf     <= h_res_ovf;
			end
		end
	end

	// v counter in 16 us ticks between selected vertical edges
	logic [11:0] vc_run, vcnt_lat;
	logic        vc_ovf, vovf;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			vc_run   <= 12'h000;
			vc_ovf   <= 1'b0;
			vcnt_lat <= 12'h000;
			vovf     <= 1'b0;
		end else if (ce_i) begin
			if (v_edge) begin
				vcnt_lat <= vc_run;
				// cleared when a period fits again
				vovf     <= vc_ovf;
				// a tick on the edge itself opens the next period
				vc_run   <= tick_v ? 12'h001 : 12'h000;
				vc_ovf   <= 1'b0;
			end else if (tick_v) begin
				if (vc_run == 12'hfff)
					vc_ovf <= 1'b1;
				else
					vc_run <= vc_run + 12'h001;
			end
		end
	end

	// change events, delayed copies of status values
	logic [2:0] pres_d;
	logic [1:0] pol_d;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pres_d <= 3'h0;
			pol_d  <= 2'h0;
		end else if (ce_i) begin
			pres_d <= pres;
			pol_d  <= pol_neg;
		end
	end
	wire ev_hf = h_take && (h_res != hcnt_lat || h_res_ovf);
	wire ev_vf = v_edge && (vc_run != vcnt_lat || vc_ovf);
	// presence changes, composite masked when the function is off
	wire ev_hpr = pres[0] ^ pres_d[0];
	wire ev_vpr = (pres[1] ^ pres_d[1]) || (comp_on && (pres[2] ^ pres_d[2]));
	wire [1:0] ev_pl = pol_neg ^ pol_d;
	hvs_flags_s ev;
	assign ev = '{hpr: ev_hpr, vpr: ev_vpr, hpl: ev_pl[0], vpl: ev_pl[1], hf: ev_hf, vf: ev_vf};

	// self-test line length per rate code
	logic [11:0] st_htot, st_hsw;
	assign st_htot = (ctl2.st_rate == 2'h3) ? 12'(`HVS_ST_HTOT2_NS / `HVS_CLK_NS) :
		(ctl2.st_rate == 2'h2) ? 12'(`HVS_ST_HTOT1_NS / `HVS_CLK_NS) : 12'(`HVS_ST_HTOT0_NS / `HVS_CLK_NS);
	assign st_hsw = (ctl2.st_rate == 2'h3) ? 12'(`HVS_ST_HSW2_NS / `HVS_CLK_NS) :
		(ctl2.st_rate == 2'h2) ? 12'(`HVS_ST_HSW1_NS / `HVS_CLK_NS) : 12'(`HVS_ST_HSW0_NS / `HVS_CLK_NS);

	// self-test counters, free running so the pattern never stops mid-frame
	logic [11:0] st_h;
	logic [8:0]  st_hcell;
	logic [20:0] st_v;
	logic [17:0] st_vcell;
	// compare with >= so a rate change never stretches a line to the counter wrap
	wire         st_hwrap = (st_h >= st_htot - 12'h001);
	wire         st_cwrap = ({3'h0, st_hcell} >= {3'h0, st_htot[11:3]} - 12'h001);
	wire         st_vwrap = (st_v == 21'(ST_VTOT_CYC - 1));
	wire         st_vcwrap = (st_vcell == 18'(ST_VTOT_CYC / 8 - 1));
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			st_h     <= 12'h000;
			st_hcell <= 9'h000;
			st_v     <= 21'h000000;
			st_vcell <= 18'h00000;
		end else if (ce_i) begin
			st_h     <= st_hwrap ? 12'h000 : st_h + 12'h001;
			st_hcell <= (st_hwrap || st_cwrap) ? 9'h000 : st_hcell + 9'h001;
			st_v     <= st_vwrap ? 21'h000000 : st_v + 21'h000001;
			st_vcell <= (st_vwrap || st_vcwrap) ? 18'h00000 : st_vcell + 18'h00001;
		end
	end
	// pattern: 8 x 8 hatch lines, inverse, white or black
	wire st_hsync = (st_h < st_hsw);
	wire st_vsync = (st_v < 21'(ST_VSW_CYC));
	wire hatch    = (st_hcell < 9'h008) || (st_vcell < {6'h00, st_htot});
	wire st_video = (ctl2.st_pat == 2'h0) ? hatch :
		(ctl2.st_pat == 2'h1) ? ~hatch : (ctl2.st_pat == 2'h2);

	wire hb_src = ctl2.st_en ? st_hsync : (use_cv ? comp_h : hs_act);
	wire vb_src = ctl2.st_en ? st_vsync : vsel;
	// frame shorter than 5 ms cuts vertical blanking
	wire v_cut  = !vovf && vsel_pres && (vcnt_lat <= 12'(`HVS_VCUT_TICKS));
	wire hb_pin = hb_src ^ ctl0.hb_neg;
	wire vb_pin = (vb_src && !v_cut) ^ ctl0.vb_neg;
	wire st_pin = ctl2.st_en && st_video && !st_hsync && !st_vsync;

	// register decode
	wire wr_ctl0  = we_i && addr_i == `HVS_A_CTRL0;
	wire wr_ctl2  = we_i && addr_i == `HVS_A_CTRL2;
	wire wr_flg   = we_i && addr_i == `HVS_A_FLAGS;
	wire wr_en    = we_i && addr_i == `HVS_A_ENABLE;
	wire wr_port4 = we_i && addr_i == `HVS_A_PORT4;
	wire wr_psel  = we_i && addr_i == `HVS_A_PINSEL;
	wire [7:0] status = {pres[2], 1'b0, ~pol_neg[0], ~pol_neg[1], pres[0], pres[1], filt[0], filt[1]};
	wire [7:0] rd_mux =
		(addr_i == `HVS_A_STATUS) ? status :
		(addr_i == `HVS_A_HCNT_HI) ? {hovf, 1'b0, hcnt_lat[13:8]} :
		(addr_i == `HVS_A_HCNT_LO) ? hcnt_lat[7:0] :
		(addr_i == `HVS_A_VCNT_HI) ? {vovf, 3'h0, vcnt_lat[11:8]} :
		(addr_i == `HVS_A_VCNT_LO) ? vcnt_lat[7:0] :
		(addr_i == `HVS_A_FLAGS)  ? {flg, 2'h0} :
		(addr_i == `HVS_A_PINSEL) ? {5'h00, pinsel} : 8'h00;

	// software registers and sticky flags
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ctl0   <= hvs_ctl0_s'(`HVS_RST_BYTE);
			ctl2   <= hvs_ctl2_s'(`HVS_RST_BYTE);
			flg    <= '0;
			flg_en <= '0;
			port4  <= 3'h0;
			pinsel <= `HVS_RST_PINSEL;
		end else if (ce_i) begin
			if (wr_ctl0)
				ctl0 <= hvs_ctl0_s'(wdata_i);
			if (wr_ctl2)
				ctl2 <= hvs_ctl2_s'(wdata_i);
			if (wr_en)
				flg_en <= hvs_flags_s'(wdata_i[7:2]);
			if (wr_port4)
				port4 <= wdata_i[2:0];
			if (wr_psel)
				pinsel <= wdata_i[2:0];
			// writing zero clears; a new event wins
			flg <= (wr_flg ? (flg & hvs_flags_s'(wdata_i[7:2])) : flg) | ev;
		end
	end

	// registered outputs and read data
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rdata_o            <= 8'h00;
			horiz_blank_out_o  <= 1'b0;
			vert_blank_out_o   <= 1'b0;
			test_pattern_out_o <= 1'b0;
			port4_o            <= 3'h0;
			irq_o              <= 1'b0;
		end else if (ce_i) begin
			rdata_o            <= re_i ? rd_mux : 8'h00;
			horiz_blank_out_o  <= hb_pin;
			vert_blank_out_o   <= vb_pin;
			test_pattern_out_o <= st_pin;
			port4_o            <= {pinsel[2] ? st_pin : port4[2], pinsel[1] ? hb_pin : port4[1],
				pinsel[0] ? vb_pin : port4[0]};
			irq_o              <= |(flg & flg_en);
		end
	end

endmodule : hvs_sync_proc
`default_nettype wire

// *** test/hvs_monitor.sv ***
// checker of the sync processor port behaviour
// assumes ce_i high and control writes only via the port
`include "hvs_params.svh"
`default_nettype none
module hvs_monitor (
	// clock and reset
	input wire logic       clock_i,
	input wire logic       rst_i,
	input wire logic       ce_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       we_i,
	input wire logic       re_i,
	input wire logic [7:0] rdata_o,
	// sync pins and outputs
	input wire logic       hsync_i,
	input wire logic       vsync_i,
	input wire logic       horiz_blank_out_o,
	input wire logic       vert_blank_out_o,
	input wire logic       test_pattern_out_o,
	input wire logic [2:0] port4_o,
	input wire logic       irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);

	logic [2:0] sel;
	logic [2:0] dat;
	logic [7:0] ctl0;
	logic [7:0] ctl2;
	logic [7:0] en;
	logic [1:0] quiet;
	wire        wr      = we_i && ce_i;
	// plain paths: no self-test, no composite, active high
	wire        h_plain = quiet == 2'h3 && !ctl2[5] && !ctl0[6] && !ctl0[1];
	wire        v_plain = quiet == 2'h3 && !ctl2[5] && !ctl0[6] && !ctl0[0];

	// shadows of the written controls, pin select also readable; quiet lets a write settle
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			{sel, dat, ctl0, ctl2, en, quiet} <= '0;
		end else begin
			if (wr && addr_i == `HVS_A_PINSEL) sel <= wdata_i[2:0];
			if (wr && addr_i == `HVS_A_PORT4) dat <= wdata_i[2:0];
			if (wr && addr_i == `HVS_A_CTRL0) ctl0 <= wdata_i;
			if (wr && addr_i == `HVS_A_CTRL2) ctl2 <= wdata_i;
			if (wr && addr_i == `HVS_A_ENABLE) en <= wdata_i;
			quiet <= wr ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
		end
	end

	property p_rd_sel;
		re_i && addr_i == `HVS_A_PINSEL |=> rdata_o == {5'h00, sel};
	endproperty
	a_rd_sel: assert property (p_rd_sel) else $error("pin select readback wrong");
	property p_port_dat;
		quiet == 2'h3 |-> (port4_o & ~sel) == (dat & ~sel);
	endproperty
	a_port_dat: assert property (p_port_dat) else $error("port data pin wrong");
	property p_port_hb;
		quiet == 2'h3 && sel[1] |-> port4_o[1] == horiz_blank_out_o || port4_o[1] == $past(horiz_blank_out_o);
	endproperty
	a_port_hb: assert property (p_port_hb) else $error("port pin lost h blanking");
	property p_irq_off;
		quiet == 2'h3 && en[7:2] == 6'h00 |-> !irq_o;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
	property p_irq_drop;
		wr && addr_i == `HVS_A_ENABLE && wdata_i[7:2] == 6'h00 |-> ##[1:2] !irq_o;
	endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("irq kept after disable");
	property p_st_idle;
		quiet == 2'h3 && !ctl2[5] |-> !test_pattern_out_o;
	endproperty
	a_st_idle: assert property (p_st_idle) else $error("test video while off");
	// either input polarity: the pin had one level 6 and 10 cycles before the rise
	property p_hb_rise;
		h_plain && $rose(horiz_blank_out_o) |-> $past(hsync_i, 6) == $past(hsync_i, 10);
	endproperty
	a_hb_rise: assert property (p_hb_rise) else $error("h blank from short pulse");
	property p_vb_rise;
		v_plain && $rose(vert_blank_out_o) |-> $past(vsync_i, 6) == $past(vsync_i, 10);
	endproperty
	a_vb_rise: assert property (p_vb_rise) else $error("v blank from short pulse");

	// main scenarios reached
	c_irq: cover property (irq_o);
	c_hb: cover property (h_plain && $rose(horiz_blank_out_o));
	c_tp: cover property (test_pattern_out_o);
endmodule : hvs_monitor

bind hvs_sync_proc hvs_monitor hvs_monitor_inst (.clock_i, .rst_i, .ce_i, .addr_i, .wdata_i, .we_i, .re_i,
	.rdata_o, .hsync_i, .vsync_i, .horiz_blank_out_o, .vert_blank_out_o, .test_pattern_out_o, .port4_o, .irq_o);
`default_nettype wire

// *** test/hvs_src.sv ***
// video source model driving the two sync pins
// assumes period and width in clock cycles; period 0 stops
`default_nettype none
module hvs_src (
	// clock
	input  wire logic        clock_i,
	// timing from the bench
	input  wire logic [31:0] hper_i,
	input  wire logic [31:0] hwid_i,
	input  wire logic [31:0] vper_i,
	input  wire logic [31:0] vwid_i,
	// sync pins
	output var  logic        hsync_o,
	output var  logic        vsync_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] hcnt;
	logic [31:0] vcnt;

	initial begin
		hcnt = '0;
		vcnt = '0;
		hsync_o = 1'b0;
		vsync_o = 1'b0;
	end

	// free counters; a stopped source idles low like a pulled cable
	always @(posedge clock_i) begin
		hcnt <= (hcnt + 1 >= hper_i) ? '0 : hcnt + 1;
		vcnt <= (vcnt + 1 >= vper_i) ? '0 : vcnt + 1;
		hsync_o <= (hper_i != 0) && (hcnt < hwid_i);
		vsync_o <= (vper_i != 0) && (vcnt < vwid_i);
	end
endmodule : hvs_src
`default_nettype wire

// *** test/hvs_sync_proc_test.sv ***
// self-checking bench of the sync processor
// assumes hvs_src as video source and the bound checker
`include "hvs_params.svh"
`default_nettype none
module hvs_sync_proc_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock_i;
	logic        rst_i;
	logic        we_i;
	logic        re_i;
	logic [7:0]  addr_i;
	logic [7:0]  wdata_i;
	logic [7:0]  rdata_o;
	logic        hsync_i;
	logic        vsync_i;
	logic        hb;
	logic        vb;
	logic        tp;
	logic        irq;
	logic [2:0]  port4_o;
	logic [31:0] hp;
	logic [31:0] hw;
	logic [31:0] vp;
	logic [31:0] vw;
	logic        seen;
	logic        last;
	int          rises[$];
	int          per;
	int          err_total;
	int          check_count;
	logic [15:0] hexp[4] = '{16'd3150, 16'd3150, 16'd2100, 16'd1575};

	// shortened frame and presence timeout keep the run short
	hvs_sync_proc #(.ST_VTOT_CYC(40000), .ST_VSW_CYC(100), .CLR_TICKS(20)) hvs_sync_proc_inst (
		.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i),
		.we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .hsync_i(hsync_i), .vsync_i(vsync_i),
		.horiz_blank_out_o(hb), .vert_blank_out_o(vb), .test_pattern_out_o(tp),
		.port4_o(port4_o), .irq_o(irq));
	hvs_src hvs_src_inst (.clock_i(clock_i), .hper_i(hp), .hwid_i(hw), .vper_i(vp), .vwid_i(vw),
		.hsync_o(hsync_i), .vsync_o(vsync_i));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// one-cycle strobes, one idle cycle after each
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		we_i <= 1'b1;
		@(posedge clock_i);
		we_i <= 1'b0;
		@(posedge clock_i);
	endtask : wr

	task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		addr_i <= a;
		re_i <= 1'b1;
		@(posedge clock_i);
		re_i <= 1'b0;
		@(negedge clock_i);
		chk(n, {8'h00, e}, {8'h00, rdata_o & m});
		@(posedge clock_i);
	endtask : rc

	task automatic summarize;
		if (err_total == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize

	// watchdog well past the expected run
	initial begin
		repeat (98000) @(posedge clock_i);
		err_total++;
		summarize();
	end

	initial begin
		{rst_i, we_i, re_i, addr_i, wdata_i} = {1'b1, 18'h0};
		{hp, hw, vp, vw} = '0;
		repeat (20) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		// reset values and refused places
		rc("flags", `HVS_A_FLAGS, 8'h00, 8'hff);
		rc("pinsel", `HVS_A_PINSEL, 8'h00, 8'hff);
		rc("unmapped", 8'h50, 8'h00, 8'hff);
		rc("enable wo", `HVS_A_ENABLE, 8'h00, 8'hff);
		// port pins: data bits beside the h blanking function
		wr(`HVS_A_PORT4, 8'h05);
		wr(`HVS_A_PINSEL, 8'h02);
		rc("pinsel", `HVS_A_PINSEL, 8'h02, 8'hff);
		repeat (3) @(posedge clock_i);
		chk("port4", 16'h0005, {13'h0, port4_o});
		wr(`HVS_A_PINSEL, 8'h00);
		// pulses of 5 cycles are noise
		{hp, hw} <= {32'd200, 32'd5};
		repeat (2000) @(posedge clock_i);
		rc("hpre noise", `HVS_A_STATUS, 8'h00, 8'h08);
		rc("flags noise", `HVS_A_FLAGS, 8'h00, 8'hff);
		// 500 kHz: 64 periods are 256 ticks of 0.5 us
		hw <= 32'd20;
		repeat (28000) @(posedge clock_i);
		rc("hcnt hi", `HVS_A_HCNT_HI, 8'h00, 8'hff);
		rc("hcnt lo", `HVS_A_HCNT_LO, 8'hff, 8'hff);
		rc("h pres pol", `HVS_A_STATUS, 8'h28, 8'h28);
		rc("h flags", `HVS_A_FLAGS, 8'h88, 8'h88);
		// interrupt: enable, mask, clear
		// irq is registered: look after the edge that launches it has settled
		wr(`HVS_A_ENABLE, 8'h80);
		@(negedge clock_i);
		chk("irq on", 16'h1, {15'h0, irq});
		wr(`HVS_A_ENABLE, 8'h00);
		@(negedge clock_i);
		chk("irq masked", 16'h0, {15'h0, irq});
		wr(`HVS_A_FLAGS, 8'h00);
		wr(`HVS_A_ENABLE, 8'hfc);
		@(negedge clock_i);
		chk("irq cleared", 16'h0, {15'h0, irq});
		rc("flags clr", `HVS_A_FLAGS, 8'h00, 8'hff);
		// high longer than low turns the polarity negative
		hw <= 32'd180;
		repeat (1500) @(posedge clock_i);
		rc("h neg", `HVS_A_STATUS, 8'h00, 8'h20);
		rc("hpl flag", `HVS_A_FLAGS, 8'h20, 8'h20);
		chk("irq pol", 16'h1, {15'h0, irq});
		// back to positive polarity, then h blanking with the input idle low
		hw <= 32'd20;
		repeat (1500) @(posedge clock_i);
		hp <= 32'd0;
		repeat (100) @(posedge clock_i);
		chk("hb pos", 16'h0, {15'h0, hb});
		wr(`HVS_A_CTRL0, 8'h02);
		repeat (2) @(posedge clock_i);
		chk("hb neg", 16'h1, {15'h0, hb});
		wr(`HVS_A_CTRL0, 8'h00);
		// 4800-cycle frame: 3 ticks of 16 us, far past the cut-off rate; short high keeps it positive
		{hp, hw, vp, vw} <= {32'd200, 32'd20, 32'd4800, 32'd1000};
		repeat (8000) @(posedge clock_i);
		rc("vcnt hi", `HVS_A_VCNT_HI, 8'h00, 8'hff);
		rc("vcnt lo", `HVS_A_VCNT_LO, 8'h03, 8'hff);
		rc("vpre", `HVS_A_STATUS, 8'h04, 8'h04);
		rc("v flags", `HVS_A_FLAGS, 8'h44, 8'h44);
		for (int c = 0; c < 4; c++) begin
			wr(`HVS_A_CTRL0, {c[1:0], 6'h00});
			wait (!vsync_i);
			wait (vsync_i);
			repeat (20) @(posedge clock_i);
			@(negedge clock_i);
			chk("vb cut", 16'h0, {15'h0, vb});
			@(posedge clock_i);
		end
		wr(`HVS_A_CTRL0, 8'h00);
		vp <= 32'd0;
		// self-test: rate code and pattern code stepped together
		for (int i = 0; i < 4; i++) begin
			wr(`HVS_A_CTRL2, {2'h0, 1'b1, i[1:0], i[1:0], 1'b0});
			rises.delete();
			seen = 1'b0;
			last = 1'b1;
			for (int n = 0; n < 7000; n++) begin
				@(negedge clock_i);
				seen |= tp;
				if (hb && !last) rises.push_back(n);
				last = hb;
			end
			per = (rises.size() > 1) ? rises[1] - rises[0] : 0;
			chk("st video", {15'h0, i < 3}, {15'h0, seen});
			chk("st hper", hexp[i], per[15:0]);
			@(posedge clock_i);
		end
		wr(`HVS_A_CTRL2, 8'h00);
		summarize();
	end
endmodule : hvs_sync_proc_test
`default_nettype wire
